// ### verilog/sbcm_pkg.sv
/*
 Constants, mode codes and state structs of the operating-mode control.
 Assumes a 100 MHz clock and a 16-bit SPI frame from the host.
*/
package sbcm_pkg;

    // ------------------------------------------------
    // Timing
    // ------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int RST_DELAY_US = 10;
    localparam int RST_DELAY_CYC = RST_DELAY_US * CLK_MHZ;
    localparam int LONG_WIN_MS = 200;
    localparam int LONG_WIN_CYC = LONG_WIN_MS * 1000 * CLK_MHZ;
    localparam int TMR_W = 25;

    // ------------------------------------------------
    // SPI frame and addresses
    // ------------------------------------------------
    localparam logic [4:0] FRAME_LEN = 5'h10;
    localparam logic [6:0] ADDR_MODE = 7'h01;
    localparam logic [6:0] ADDR_WD = 7'h03;

    // ------------------------------------------------
    // Operating mode field codes
    // ------------------------------------------------
    localparam logic [2:0] FIELD_NORMAL = 3'h0;
    localparam logic [2:0] FIELD_STOP = 3'h1;
    localparam logic [2:0] FIELD_SLEEP = 3'h2;
    localparam logic [2:0] FIELD_SOFT_RST = 3'h3;

    typedef enum logic [2:0] {
        ST_INIT = 3'b000,
        ST_NORMAL = 3'b001,
        ST_STOP = 3'b010,
        ST_SLEEP = 3'b011,
        ST_RESTART = 3'b100,
        ST_FAILSAFE = 3'b101
    } sbcm_mode_e;

    typedef struct packed {
        logic wr;
        logic [6:0] addr;
        logic [7:0] data;
    } sbcm_frame_s;

    typedef struct packed {
        logic csPrev;
        logic sckPrev;
        logic [4:0] bitCnt;
        logic [15:0] rx;
        logic [15:0] tx;
        logic valid;
        sbcm_frame_s word;
        logic miso;
    } sbcm_spi_s;

    typedef struct packed {
        logic [TMR_W-1:0] cnt;
        logic expired;
    } sbcm_tmr_s;

    typedef struct packed {
        sbcm_mode_e state;
        logic [2:0] field;
        logic devMode;
        logic failCnt;
        logic rstOutN;
        logic buckEn;
        logic wdRun;
        logic delayStart;
        logic wdStart;
        logic wdExpPrev;
    } sbcm_ctl_s;

endpackage

// ### verilog/sbcm_timer.sv
/*
 One-shot cycle timer: restarts on start, raises expired after limit cycles.
 Assumes start is a one-cycle pulse and limit is at least one.
*/
`timescale 1ns/1ps
module sbcm_timer (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic run,
    input wire logic [sbcm_pkg::TMR_W-1:0] limit,
    output logic expired
);

    sbcm_pkg::sbcm_tmr_s q, d;

    always_comb begin
        d = q;
        if (start) begin
            d.cnt = '0;
            d.expired = 1'b0;
        end else if (run && !q.expired) begin
            if (q.cnt == limit - 1'b1) begin
                d.expired = 1'b1;
            end else begin
                d.cnt = q.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign expired = q.expired;

endmodule // sbcm_timer

// ### verilog/sbcm_spi_slave.sv
/*
 16-bit SPI slave, mode 0, MSB first, reply word loaded at select.
 Assumes SPI pins synchronous to clk and slower than a quarter of it.
*/
`timescale 1ns/1ps
module sbcm_spi_slave (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic csN,
    input wire logic sck,
    input wire logic mosi,
    input wire logic [15:0] txWord,
    output logic miso,
    output logic frameValid,
    output sbcm_pkg::sbcm_frame_s frame
);

    sbcm_pkg::sbcm_spi_s q, d;

    always_comb begin
        d = q;
        d.valid = 1'b0;
        d.csPrev = csN;
        d.sckPrev = sck;
        if (q.csPrev && !csN) begin
            d.tx = txWord;
            d.bitCnt = '0;
            d.miso = txWord[15];
        end else if (!csN) begin
            if (!q.sckPrev && sck) begin
                d.rx = {q.rx[14:0], mosi};
                if (!(&q.bitCnt)) begin
                    d.bitCnt = q.bitCnt + 1'b1;
                end
            end
            if (q.sckPrev && !sck) begin
                d.tx = {q.tx[14:0], 1'b0};
                d.miso = q.tx[14];
            end
        end
        // Only whole 16-bit frames count
        if (!q.csPrev && csN && q.bitCnt == sbcm_pkg::FRAME_LEN) begin
            d.valid = 1'b1;
            d.word = q.rx;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
            q.csPrev <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign miso = q.miso;
    assign frameValid = q.valid;
    assign frame = q.word;

endmodule // sbcm_spi_slave

// ### verilog/sbcm_mode_ctrl.sv
/*
 Operating-mode state machine with SPI command path and watchdog window.
 Assumes wake, fault and strap inputs synchronous to clk.
*/
// Functional notes
// - Mode commands and status pass over the 16-bit SPI link; watchdog config comes from the cfgFailSafe and cfgSecondFail pins.
// - Host writes the mode field; the device enters the requested mode.
// - Power-up and soft reset both lead to initialisation mode.
// - Stop mode keeps the main regulator on.
// - Sleep mode turns the buck regulator off.
// - Wake in sleep or fail-safe leads to restart mode.
// - Watchdog failure in configurations 1 or 3 gives restart and host reset.
// - Restart ends in normal mode after the reset delay once fault clears.
// - Second-level thermal shutdown forces fail-safe mode.
// - Fail-safe mode keeps the buck regulator off.
// - Passing restart clears the mode field so it shows the active mode.
// - Debug strap low during initialisation selects development mode.
// - Development mode halts the watchdog counter.
// - Development mode keeps all normal mode transitions except those on watchdog failure.
// - Host reset release starts the watchdog with a 200 ms long window.
`timescale 1ns/1ps
module sbcm_mode_ctrl #(
    parameter int RESET_DELAY_CYC = sbcm_pkg::RST_DELAY_CYC,
    parameter int LONG_WIN_CYC = sbcm_pkg::LONG_WIN_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic spiCsN,
    input wire logic spiSck,
    input wire logic spiMosi,
    output logic spiMiso,
    input wire logic wakeEvent,
    input wire logic thermalShutdownLevelTwo,
    input wire logic restartFault,
    input wire logic debugStrapN,
    input wire logic cfgFailSafe,
    input wire logic cfgSecondFail,
    output logic hostResetOutN,
    output logic buckEnable,
    output logic devMode,
    output logic [2:0] activeMode,
    output logic watchdogRunning
);

    // ------------------------------------------------
    // Declarations
    // ------------------------------------------------
    sbcm_pkg::sbcm_ctl_s q, d;
    sbcm_pkg::sbcm_frame_s frame;
    logic frameValid;
    logic [15:0] txWord;
    logic delayDone;
    logic wdExpired;
    logic wdFailEv;
    logic wrMode;
    logic wrWd;
    logic [2:0] reqField;
    logic [sbcm_pkg::TMR_W-1:0] delayLimit;
    logic [sbcm_pkg::TMR_W-1:0] winLimit;

    assign delayLimit = sbcm_pkg::TMR_W'(RESET_DELAY_CYC);
    assign winLimit = sbcm_pkg::TMR_W'(LONG_WIN_CYC);

    // ------------------------------------------------
    // SPI link and timers
    // ------------------------------------------------
    assign txWord = {8'h00, q.devMode, q.state, 1'b0, q.field};

    sbcm_spi_slave u_spi (
        .clk(clk),
        .rst_n(rst_n),
        .csN(spiCsN),
        .sck(spiSck),
        .mosi(spiMosi),
        .txWord(txWord),
        .miso(spiMiso),
        .frameValid(frameValid),
        .frame(frame)
    );

    sbcm_timer u_delay (
        .clk(clk),
        .rst_n(rst_n),
        .start(q.delayStart),
        .run(1'b1),
        .limit(delayLimit),
        .expired(delayDone)
    );

    sbcm_timer u_wd (
        .clk(clk),
        .rst_n(rst_n),
        .start(q.wdStart),
        .run(q.wdRun),
        .limit(winLimit),
        .expired(wdExpired)
    );

    assign wrMode = frameValid && frame.wr
        && frame.addr == sbcm_pkg::ADDR_MODE;
    assign wrWd = frameValid && frame.wr && frame.addr == sbcm_pkg::ADDR_WD;
    assign reqField = frame.data[2:0];
    assign wdFailEv = wdExpired && !q.wdExpPrev;

    // ------------------------------------------------
    // Mode state machine
    // ------------------------------------------------
    always_comb begin
        d = q;
        d.delayStart = 1'b0;
        d.wdStart = wrWd;
        d.wdExpPrev = wdExpired;
        case (q.state)
            sbcm_pkg::ST_INIT,
            sbcm_pkg::ST_NORMAL,
            sbcm_pkg::ST_STOP: begin
                if (q.state == sbcm_pkg::ST_INIT && !q.rstOutN) begin
                    d.devMode = !debugStrapN;
                    if (delayDone && !q.delayStart) begin
                        d.rstOutN = 1'b1;
                        d.wdStart = 1'b1;
                    end
                end else if (wdFailEv) begin
                    if (cfgSecondFail && !q.failCnt) begin
                        d.failCnt = 1'b1;
                        d.wdStart = 1'b1;
                    end else if (cfgFailSafe) begin
                        d.failCnt = 1'b0;
                        d.state = sbcm_pkg::ST_FAILSAFE;
                        d.rstOutN = 1'b0;
                    end else begin
                        d.failCnt = 1'b0;
                        d.state = sbcm_pkg::ST_RESTART;
                        d.field = sbcm_pkg::FIELD_NORMAL;
                        d.rstOutN = 1'b0;
                        d.delayStart = 1'b1;
                    end
                end else if (wrMode) begin
                    case (reqField)
                        sbcm_pkg::FIELD_NORMAL: begin
                            d.state = sbcm_pkg::ST_NORMAL;
                            d.field = reqField;
                        end
                        sbcm_pkg::FIELD_STOP: begin
                            d.state = sbcm_pkg::ST_STOP;
                            d.field = reqField;
                        end
                        sbcm_pkg::FIELD_SLEEP: begin
                            d.state = sbcm_pkg::ST_SLEEP;
                            d.field = reqField;
                        end
                        sbcm_pkg::FIELD_SOFT_RST: begin
                            d.state = sbcm_pkg::ST_INIT;
                            d.field = sbcm_pkg::FIELD_NORMAL;
                            d.rstOutN = 1'b0;
                            d.delayStart = 1'b1;
                            d.failCnt = 1'b0;
                        end
                        default: begin
                        end
                    endcase
                end else if (q.state == sbcm_pkg::ST_STOP && wakeEvent) begin
                    d.state = sbcm_pkg::ST_NORMAL;
                    d.field = sbcm_pkg::FIELD_NORMAL;
                end
            end
            sbcm_pkg::ST_SLEEP,
            sbcm_pkg::ST_FAILSAFE: begin
                if (wakeEvent) begin
                    d.state = sbcm_pkg::ST_RESTART;
                    d.field = sbcm_pkg::FIELD_NORMAL;
                    d.rstOutN = 1'b0;
                    d.delayStart = 1'b1;
                end
            end
            sbcm_pkg::ST_RESTART: begin
                if (delayDone && !q.delayStart && !restartFault) begin
                    d.state = sbcm_pkg::ST_NORMAL;
                    d.rstOutN = 1'b1;
                    d.wdStart = 1'b1;
                end
            end
            default: begin
                d.state = sbcm_pkg::ST_INIT;
            end
        endcase
        if (thermalShutdownLevelTwo) begin
            d.state = sbcm_pkg::ST_FAILSAFE;
            d.rstOutN = 1'b0;
        end
        d.buckEn = !(d.state == sbcm_pkg::ST_SLEEP
            || d.state == sbcm_pkg::ST_FAILSAFE);
        d.wdRun = d.rstOutN && !d.devMode
            && (d.state == sbcm_pkg::ST_INIT
            || d.state == sbcm_pkg::ST_NORMAL
            || d.state == sbcm_pkg::ST_STOP);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
            q.state <= sbcm_pkg::ST_INIT;
            q.buckEn <= 1'b1;
            q.delayStart <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign hostResetOutN = q.rstOutN;
    assign buckEnable = q.buckEn;
    assign devMode = q.devMode;
    assign activeMode = q.state;
    assign watchdogRunning = q.wdRun;

    // ------------------------------------------------
    // Checks
    // ------------------------------------------------
    stop_reg_on_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        q.state == sbcm_pkg::ST_STOP |-> buckEnable)
        else $error("Regulator off in stop mode");

    sleep_buck_off_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        q.state == sbcm_pkg::ST_SLEEP |-> !buckEnable)
        else $error("Buck on in sleep mode");

    failsafe_buck_off_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        q.state == sbcm_pkg::ST_FAILSAFE |-> !buckEnable && !hostResetOutN)
        else $error("Buck on in fail-safe mode");

    wake_restart_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (q.state == sbcm_pkg::ST_SLEEP && wakeEvent
            && !thermalShutdownLevelTwo)
        |=> q.state == sbcm_pkg::ST_RESTART ##1 !hostResetOutN)
        else $error("Wake in sleep did not restart");

    tsd_failsafe_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        thermalShutdownLevelTwo |=> q.state == sbcm_pkg::ST_FAILSAFE)
        else $error("Thermal shutdown missed fail-safe");

    restart_hold_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (q.state == sbcm_pkg::ST_RESTART && restartFault)
        |=> q.state != sbcm_pkg::ST_NORMAL)
        else $error("Restart left while fault present");

    restart_clear_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        q.state == sbcm_pkg::ST_RESTART |-> q.field == 3'h0)
        else $error("Mode field not cleared in restart");

    restart_reset_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        $rose(hostResetOutN) |-> q.state != sbcm_pkg::ST_RESTART
            && $past(q.state) != sbcm_pkg::ST_FAILSAFE)
        else $error("Host reset released in wrong mode");

    dev_wd_halt_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        q.devMode && $past(q.devMode) |-> !watchdogRunning && !wdFailEv)
        else $error("Watchdog running in development mode");

    strap_dev_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (q.state == sbcm_pkg::ST_INIT && !q.rstOutN && !debugStrapN)
        |=> q.devMode)
        else $error("Strap did not select development mode");

    window_start_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        $rose(hostResetOutN) |-> q.wdStart)
        else $error("Long window not started at reset release");

    mode_req_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (q.state == sbcm_pkg::ST_NORMAL && wrMode
            && reqField == sbcm_pkg::FIELD_SLEEP
            && !wdFailEv && !thermalShutdownLevelTwo)
        |=> q.state == sbcm_pkg::ST_SLEEP && q.field == reqField)
        else $error("Requested sleep mode not entered");

    soft_reset_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (q.state == sbcm_pkg::ST_NORMAL && wrMode
            && reqField == sbcm_pkg::FIELD_SOFT_RST
            && !wdFailEv && !thermalShutdownLevelTwo)
        |=> q.state == sbcm_pkg::ST_INIT && !hostResetOutN)
        else $error("Soft reset did not enter init");

    second_fail_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wdFailEv && q.state == sbcm_pkg::ST_NORMAL && cfgSecondFail
            && !q.failCnt && !thermalShutdownLevelTwo)
        |=> q.state == sbcm_pkg::ST_NORMAL && q.failCnt)
        else $error("First failure left normal in config 3");

    wd_fail_restart_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wdFailEv && q.state == sbcm_pkg::ST_NORMAL && !cfgFailSafe
            && !(cfgSecondFail && !q.failCnt)
            && !thermalShutdownLevelTwo)
        |=> q.state == sbcm_pkg::ST_RESTART && !hostResetOutN
            && q.field == sbcm_pkg::FIELD_NORMAL)
        else $error("Watchdog failure did not restart");

endmodule // sbcm_mode_ctrl

// ### bench/sbcm_host_model.sv
/*
 Host side model: SPI master sending frames of nbits bits, mode 0, MSB first.
 Assumes the slave samples on sck rise and needs two clk cycles per half.
*/
`timescale 1ns/1ps
module sbcm_host_model (
    input wire logic clk,
    output logic spiCsN,
    output logic spiSck,
    output logic spiMosi,
    input wire logic spiMiso
);
    // ------------------------------------------------
    // Idle levels
    // ------------------------------------------------
    initial begin
        spiCsN = 1'b1;
        spiSck = 1'b0;
        spiMosi = 1'b0;
    end

    // ------------------------------------------------
    // Frame transfer
    // ------------------------------------------------
    task automatic xfer(input logic [15:0] w, input int nbits,
                        output logic [15:0] rx);
        int i;
        rx = 16'h0000;
        @(posedge clk);
        spiCsN <= 1'b0;
        spiMosi <= w[15];
        for (i = 0; i < nbits; i++) begin
            repeat (2) @(posedge clk);
            spiSck <= 1'b1;
            rx = {rx[14:0], spiMiso};
            repeat (2) @(posedge clk);
            spiSck <= 1'b0;
            spiMosi <= (i < 15) ? w[14 - i] : w[0];
        end
        repeat (2) @(posedge clk);
        spiCsN <= 1'b1;
        spiMosi <= ~spiMosi;
        repeat (5) @(posedge clk);
    endtask
endmodule // sbcm_host_model

// ### bench/tb_top.sv
/*
 Self-checking bench of the operating-mode control.
 Assumes shortened reset delay and watchdog window parameters.
*/
`timescale 1ns/1ps
module tb_top;
    localparam int RD = 20;
    localparam int LW = 2000;

    typedef struct packed {
        logic wake;
        logic [4:0] nbits;
        logic [15:0] word;
        logic [2:0] mode;
        logic buck;
    } sbcm_row_s;

    localparam sbcm_row_s ROWS [10] = '{
        '{1'b0, 5'h10, 16'h8100, 3'h1, 1'b1},
        '{1'b0, 5'h0f, 16'h8101, 3'h1, 1'b1},
        '{1'b0, 5'h11, 16'h4081, 3'h1, 1'b1},
        '{1'b0, 5'h10, 16'h8105, 3'h1, 1'b1},
        '{1'b0, 5'h10, 16'h8201, 3'h1, 1'b1},
        '{1'b1, 5'h00, 16'h0000, 3'h1, 1'b1},
        '{1'b0, 5'h10, 16'h8101, 3'h2, 1'b1},
        '{1'b1, 5'h00, 16'h0000, 3'h1, 1'b1},
        '{1'b0, 5'h10, 16'h8102, 3'h3, 1'b0},
        '{1'b1, 5'h00, 16'h0000, 3'h4, 1'b1}
    };

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic spiCsN, spiSck, spiMosi, spiMiso;
    logic wakeEvent = 1'b0;
    logic thermalShutdownLevelTwo = 1'b0;
    logic restartFault = 1'b0;
    logic debugStrapN = 1'b1;
    logic cfgFailSafe = 1'b0;
    logic cfgSecondFail = 1'b0;
    logic hostResetOutN, buckEnable, devMode, watchdogRunning;
    logic [2:0] activeMode;
    logic [15:0] reply;
    int error_cnt = 0;
    int n_tests = 0;

    always #5 clk = ~clk;

    sbcm_mode_ctrl #(.RESET_DELAY_CYC(RD), .LONG_WIN_CYC(LW)) dut (
        .clk(clk), .rst_n(rst_n), .spiCsN(spiCsN), .spiSck(spiSck),
        .spiMosi(spiMosi), .spiMiso(spiMiso), .wakeEvent(wakeEvent),
        .thermalShutdownLevelTwo(thermalShutdownLevelTwo),
        .restartFault(restartFault), .debugStrapN(debugStrapN),
        .cfgFailSafe(cfgFailSafe), .cfgSecondFail(cfgSecondFail),
        .hostResetOutN(hostResetOutN), .buckEnable(buckEnable),
        .devMode(devMode), .activeMode(activeMode),
        .watchdogRunning(watchdogRunning)
    );

    sbcm_host_model host (
        .clk(clk), .spiCsN(spiCsN), .spiSck(spiSck),
        .spiMosi(spiMosi), .spiMiso(spiMiso)
    );

    // ------------------------------------------------
    // Compare and wait helpers
    // ------------------------------------------------
    task automatic rep(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic chk_mode(input logic [2:0] got, input logic [2:0] exp);
        rep({13'h0000, got}, {13'h0000, exp});
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        rep({15'h0000, got}, {15'h0000, exp});
    endtask

    task automatic wait_mode(input logic [2:0] exp, input int lim);
        int i;
        @(negedge clk);
        for (i = 0; i < lim && activeMode !== exp; i++) @(negedge clk);
        chk_mode(activeMode, exp);
    endtask

    task automatic wait_rst(input int lim);
        int i;
        @(negedge clk);
        for (i = 0; i < lim && hostResetOutN !== 1'b1; i++) @(negedge clk);
        chk_flag(hostResetOutN, 1'b1);
    endtask

    task automatic frame(input logic [15:0] w);
        host.xfer(w, 16, reply);
    endtask

    task automatic wake;
        @(posedge clk);
        wakeEvent <= 1'b1;
        @(posedge clk);
        wakeEvent <= 1'b0;
    endtask

    task automatic give_verdict;
        if (error_cnt == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ------------------------------------------------
    // Watchdog
    // ------------------------------------------------
    initial begin
        repeat (30000) @(posedge clk);
        error_cnt++;
        give_verdict();
    end

    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial begin
        repeat (15) @(posedge clk);
        @(negedge clk);
        chk_mode(activeMode, sbcm_pkg::ST_INIT);
        chk_flag(hostResetOutN, 1'b0);
        chk_flag(buckEnable, 1'b1);
        chk_flag(devMode | watchdogRunning | spiMiso, 1'b0);
        @(posedge clk);
        rst_n <= 1'b1;
        wait_rst(RD + 10);
        chk_flag(watchdogRunning, 1'b1);
        foreach (ROWS[k]) begin
            if (ROWS[k].wake) begin
                wake();
            end else begin
                host.xfer(ROWS[k].word, int'(ROWS[k].nbits), reply);
            end
            wait_mode(ROWS[k].mode, 6);
            chk_flag(buckEnable, ROWS[k].buck);
        end
        chk_flag(hostResetOutN, 1'b0);
        wait_mode(sbcm_pkg::ST_NORMAL, RD + 10);
        chk_flag(hostResetOutN, 1'b1);
        frame(16'h0000);
        rep(reply, {8'h00, 1'b0, sbcm_pkg::ST_NORMAL, 1'b0,
                    sbcm_pkg::FIELD_NORMAL});
        // Watchdog failure, restart path held by a fault
        repeat (LW - 200) @(posedge clk);
        restartFault <= 1'b1;
        wait_mode(sbcm_pkg::ST_NORMAL, 1);
        wait_mode(sbcm_pkg::ST_RESTART, 400);
        chk_flag(hostResetOutN, 1'b0);
        repeat (RD + 30) @(posedge clk);
        wait_mode(sbcm_pkg::ST_RESTART, 1);
        @(posedge clk);
        restartFault <= 1'b0;
        wait_mode(sbcm_pkg::ST_NORMAL, RD + 10);
        // Trigger write rearms the window; a fault would pin restart
        repeat (LW - 300) @(posedge clk);
        frame(16'h8300);
        restartFault <= 1'b1;
        repeat (400) @(posedge clk);
        wait_mode(sbcm_pkg::ST_NORMAL, 1);
        // Config 3: first failure only rearms, second restarts
        @(posedge clk);
        restartFault <= 1'b0;
        cfgSecondFail <= 1'b1;
        repeat (LW + 100) @(posedge clk);
        wait_mode(sbcm_pkg::ST_NORMAL, 1);
        wait_mode(sbcm_pkg::ST_RESTART, LW + 100);
        @(posedge clk);
        cfgSecondFail <= 1'b0;
        wait_mode(sbcm_pkg::ST_NORMAL, RD + 10);
        // Watchdog failure into fail-safe, wake out of it
        @(posedge clk);
        cfgFailSafe <= 1'b1;
        wait_mode(sbcm_pkg::ST_FAILSAFE, LW + 100);
        chk_flag(buckEnable, 1'b0);
        wake();
        wait_mode(sbcm_pkg::ST_RESTART, 4);
        wait_mode(sbcm_pkg::ST_NORMAL, RD + 10);
        // Thermal shutdown from normal
        @(posedge clk);
        cfgFailSafe <= 1'b0;
        thermalShutdownLevelTwo <= 1'b1;
        @(posedge clk);
        thermalShutdownLevelTwo <= 1'b0;
        wait_mode(sbcm_pkg::ST_FAILSAFE, 4);
        chk_flag(buckEnable, 1'b0);
        wake();
        wait_mode(sbcm_pkg::ST_NORMAL, RD + 20);
        // Soft reset with strap low gives development mode
        @(posedge clk);
        debugStrapN <= 1'b0;
        frame(16'h8103);
        wait_mode(sbcm_pkg::ST_INIT, 4);
        wait_rst(RD + 10);
        chk_flag(devMode, 1'b1);
        chk_flag(watchdogRunning, 1'b0);
        @(posedge clk);
        debugStrapN <= 1'b1;
        frame(16'h8100);
        wait_mode(sbcm_pkg::ST_NORMAL, 4);
        frame(16'h8101);
        wait_mode(sbcm_pkg::ST_STOP, 4);
        repeat (LW + 100) @(posedge clk);
        wait_mode(sbcm_pkg::ST_STOP, 1);
        wake();
        wait_mode(sbcm_pkg::ST_NORMAL, 4);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk_flag(devMode, 1'b0);
        chk_mode(activeMode, sbcm_pkg::ST_INIT);
        give_verdict();
    end
endmodule // tb_top
